// file: rtl/rtc_map.svh
// Address map, field masks, reset values and timing constants of the clock core
`ifndef RTC_MAP_SVH
`define RTC_MAP_SVH
// Clock register addresses
`define A_SEC 7'h00
`define A_MIN 7'h01
`define A_HOUR 7'h02
`define A_DAY 7'h03
`define A_DATE 7'h04
`define A_MON 7'h05
`define A_YEAR 7'h06
// Pointer space limits
`define CLK_BASE 7'h00
`define CLK_TOP 7'h1F
`define RAM_BASE 7'h20
`define RAM_TOP 7'h7F
`define RAM_DEPTH 96
// Writable bits of each time register; the rest are constant zero
`define M_SEC 8'h7F
`define M_MIN 8'h7F
`define M_HOUR 8'h7F
`define M_DAY 8'h07
`define M_DATE 8'h3F
`define M_MON 8'h9F
`define M_YEAR 8'hFF
// Power-on values: 00:00:00 01/01/00, weekday 01
`define R_SEC 8'h00
`define R_MIN 8'h00
`define R_HOUR 8'h00
`define R_DAY 8'h01
`define R_DATE 8'h01
`define R_MON 8'h01
`define R_YEAR 8'h00
// Field positions
`define HOUR_12_BIT 6
`define HOUR_PM_BIT 5
`define CENTURY_BIT 7
`define WR_FLAG_BIT 7
// Timebase crystal frequency in Hz
`define OSC_HZ 32768
`endif

// file: rtl/rtc_pkg.sv
// Types shared by the clock core
package rtc_pkg;
    // Phase of a serial frame, one-hot
    typedef enum logic [2:0] {
        ST_ADDR  = 3'b001,
        ST_WRITE = 3'b010,
        ST_READ  = 3'b100
    } xfer_state_t;
endpackage

// file: rtl/user_ram.sv
// Battery-backed user byte store with registered read data
module user_ram #(
    parameter int DEPTH = 96,
    parameter int WIDTH = 8
) (
    input wire logic mclk,
    input wire logic we,
    input wire logic [6:0] waddr,
    input wire logic [WIDTH-1:0] wdata,
    input wire logic [6:0] raddr,
    output logic [WIDTH-1:0] rdata_r
);
    // Storage array, contents undefined at power-up
    logic [WIDTH-1:0] mem [DEPTH];

    // Write port
    always_ff @(posedge mclk) begin
        if (we && (int'(waddr) < DEPTH)) begin
            mem[waddr] <= wdata;
        end
    end

    // Read port, out of range reads give zero
    always_ff @(posedge mclk) begin
        if (int'(raddr) < DEPTH) begin
            rdata_r <= mem[raddr];
        end else begin
            rdata_r <= '0;
        end
    end
endmodule

// file: rtl/serial_link.sv
// Serial shifter on the link clock: bytes in, read bytes out
`include "rtc_map.svh"
module serial_link (
    input wire logic sclk,
    input wire logic srst,
    input wire logic ce,
    input wire logic sdi,
    input wire logic interface_select,
    input wire logic [7:0] tx_data,
    output logic rx_tog_r,
    output logic [7:0] rx_byte_r,
    output logic sdo_r,
    output logic sdo_oe_n_r
);
    logic [2:0] bit_cnt_r; // Bits taken in current byte
    logic [6:0] sh_in_r; // Incoming bits
    logic [6:0] sh_out_r; // Outgoing bits still to send
    logic first_done_r; // Address byte complete
    logic rd_phase_r; // Frame is a read
    logic sel_m_r; // Mode strap, first stage
    logic sel_r; // Mode strap, second stage
    logic [7:0] byte_in; // Byte completing this edge

    assign byte_in = {sh_in_r, sdi};

    // Mode strap sync; static pin, only settled value is used
    always_ff @(posedge sclk or posedge srst) begin
        if (srst) begin
            sel_m_r <= 1'b0;
            sel_r <= 1'b0;
        end else begin
            sel_m_r <= interface_select;
            sel_r <= sel_m_r;
        end
    end

    // Input shifter; frame state dies with chip enable, clock may stop
    always_ff @(posedge sclk or negedge ce) begin
        if (!ce) begin
            bit_cnt_r <= 3'h0;
            sh_in_r <= 7'h00;
            first_done_r <= 1'b0;
            rd_phase_r <= 1'b0;
        end else begin
            sh_in_r <= byte_in[6:0];
            bit_cnt_r <= bit_cnt_r + 3'h1;
            if (bit_cnt_r == 3'h7 && !first_done_r) begin
                first_done_r <= 1'b1;
                rd_phase_r <= ~byte_in[`WR_FLAG_BIT];
            end
        end
    end

    // Completed byte and event toggle; toggle survives across frames
    always_ff @(posedge sclk or posedge srst) begin
        if (srst) begin
            rx_tog_r <= 1'b0;
            rx_byte_r <= 8'h00;
        end else if (bit_cnt_r == 3'h7) begin
            rx_byte_r <= byte_in;
            rx_tog_r <= ~rx_tog_r;
        end
    end

    // Output shifter; tx_data is held steady by the core before this edge
    always_ff @(negedge sclk or negedge ce) begin
        if (!ce) begin
            sh_out_r <= 7'h00;
            sdo_r <= 1'b0;
            sdo_oe_n_r <= 1'b1;
        end else if (rd_phase_r) begin
            sdo_oe_n_r <= 1'b0;
            if (bit_cnt_r == 3'h0) begin
                sdo_r <= tx_data[7];
                sh_out_r <= tx_data[6:0];
            end else begin
                sdo_r <= sh_out_r[6];
                sh_out_r <= {sh_out_r[5:0], 1'b0};
            end
        end else begin
            // Shared data pin in three-wire mode stays released
            sdo_oe_n_r <= ~sel_r;
            sdo_r <= 1'b0;
        end
    end
endmodule

// file: rtl/bcd_clock_calendar_core.sv
// Timekeeping core: BCD calendar, shadow read set, pointer and user RAM
// Functional notes
// - Clock pointer wraps 1Fh to 00h
// - RAM pointer wraps 7Fh to 20h
// - Copy time on CE rise, clock pointer wrap
// - Reads come from frozen copy
// - BCD counting, host writes set time
// - Weekday steps at midnight, 7 to 1
// - Month lengths and leap years to 2099
// - Hours bit 6 selects 12-hour form
// - Bit 5 is PM or twenties digit
// - Century bit flips on year 99 to 00
// - Reset gives 00:00:00 01/01/00, day 01
// - Power fail blocks clock register access
// - Bursts auto-advance within one CE period
// - Sealed: no backup until power first good
// - Time runs only with oscillator, and only with supply while sealed
// - Second tick divided from 32.768kHz
// - Ninety-six bytes of user RAM
// - Mode pin: low three-wire, high SPI
// - Constant-zero bits read zero always
`include "rtc_map.svh"
module bcd_clock_calendar_core import rtc_pkg::*; #(
    parameter int OSC_DIV = `OSC_HZ
) (
    input wire logic mclk,
    input wire logic srst,
    input wire logic sclk,
    input wire logic ce,
    input wire logic sdi,
    input wire logic interface_select,
    input wire logic osc_32k,
    input wire logic osc_run,
    input wire logic vcc_below_threshold,
    output logic sdo,
    output logic sdo_oe_n
);
    // Two-stage synchronisers and one delay stage for edges
    logic ce_m_r, ce_s_r, ce_d_r;
    logic osc_m_r, osc_s_r, osc_d_r;
    logic run_m_r, run_s_r;
    logic pf_m_r, pf_s_r;
    logic tog_m_r, tog_s_r, tog_d_r;
    // Link side results
    logic rx_tog;
    logic [7:0] rx_byte;
    logic [7:0] tx_data_r; // Byte offered to the shifter
    logic [7:0] tx_nxt;
    // Frame control
    xfer_state_t state_r;
    logic [6:0] ptr_r, ptr_nxt;
    logic ptr_wrap; // Clock space pointer wrapped
    // Main time counters and frozen copies
    logic [7:0] sec_r, min_r, hour_r, day_r, date_r, mon_r, year_r;
    logic [7:0] sec_nxt, min_nxt, hour_nxt, day_nxt, date_nxt, mon_nxt, year_nxt;
    logic [7:0] sh_sec_r, sh_min_r, sh_hour_r, sh_day_r, sh_date_r, sh_mon_r, sh_year_r;
    logic [15:0] div_r; // Oscillator edge count
    logic sealed_r; // No backup until power first seen good
    logic ce_rise, osc_rise, byte_evt, sec_tick, tick_en, copy_en, clk_wr, ram_we;
    logic midnight; // Hour rollover into a new day
    logic [7:0] hr_step, mo_step; // Twelve-hour and month steps, low five bits used
    logic [7:0] ram_rdata;

    // BCD increment with wrap from top back to bottom
    function automatic logic [7:0] bcd_inc(input logic [7:0] v, input logic [7:0] top,
                                           input logic [7:0] bot);
        if (v == top) begin
            return bot;
        end else if (v[3:0] == 4'h9) begin
            return {v[7:4] + 4'h1, 4'h0};
        end else begin
            return v + 8'h01;
        end
    endfunction

    // Last date of a month; years divisible by four are leap
    function automatic logic [7:0] last_date(input logic [4:0] mon, input logic [7:0] yr);
        logic leap;
        leap = (!yr[4] && (yr[3:0] == 4'h0 || yr[3:0] == 4'h4 || yr[3:0] == 4'h8)) ||
               (yr[4] && (yr[3:0] == 4'h2 || yr[3:0] == 4'h6));
        if (mon == 5'h02) begin
            return leap ? 8'h29 : 8'h28;
        end else if (mon == 5'h04 || mon == 5'h06 || mon == 5'h09 || mon == 5'h11) begin
            return 8'h30;
        end else begin
            return 8'h31;
        end
    endfunction

    // Link logic on its own clock
    serial_link u_link (
        .sclk(sclk),
        .srst(srst),
        .ce(ce),
        .sdi(sdi),
        .interface_select(interface_select),
        .tx_data(tx_data_r),
        .rx_tog_r(rx_tog),
        .rx_byte_r(rx_byte),
        .sdo_r(sdo),
        .sdo_oe_n_r(sdo_oe_n)
    );

    // User byte store
    user_ram #(.DEPTH(`RAM_DEPTH), .WIDTH(8)) u_ram (
        .mclk(mclk),
        .we(ram_we),
        .waddr(7'(ptr_r - `RAM_BASE)),
        .wdata(rx_byte),
        .raddr(7'(ptr_r - `RAM_BASE)),
        .rdata_r(ram_rdata)
    );

    // Pin and link-clock inputs into the core clock
    always_ff @(posedge mclk) begin
        if (srst) begin
            {ce_m_r, ce_s_r, ce_d_r} <= 3'h0;
            {osc_m_r, osc_s_r, osc_d_r} <= 3'h0;
            // Supply taken as failing until seen good, so reset never lifts the seal
            {run_m_r, run_s_r, pf_m_r, pf_s_r} <= 4'h3;
            {tog_m_r, tog_s_r, tog_d_r} <= 3'h0;
        end else begin
            {ce_m_r, ce_s_r, ce_d_r} <= {ce, ce_m_r, ce_s_r};
            {osc_m_r, osc_s_r, osc_d_r} <= {osc_32k, osc_m_r, osc_s_r};
            {run_m_r, run_s_r} <= {osc_run, run_m_r};
            {pf_m_r, pf_s_r} <= {vcc_below_threshold, pf_m_r};
            {tog_m_r, tog_s_r, tog_d_r} <= {rx_tog, tog_m_r, tog_s_r};
        end
    end

    assign ce_rise = ce_s_r & ~ce_d_r;
    assign osc_rise = osc_s_r & ~osc_d_r;
    assign byte_evt = tog_s_r ^ tog_d_r;

    // Second divider on crystal edges; held while oscillator stopped
    always_ff @(posedge mclk) begin
        if (srst) begin
            div_r <= 16'h0000;
        end else if (osc_rise && run_s_r) begin
            div_r <= (div_r == 16'(OSC_DIV - 1)) ? 16'h0000 : div_r + 16'h0001;
        end
    end

    assign sec_tick = osc_rise && run_s_r && (div_r == 16'(OSC_DIV - 1));

    // Seal lifts once supply is first good, returns only with reset
    always_ff @(posedge mclk) begin
        if (srst) begin
            sealed_r <= 1'b1;
        end else if (!pf_s_r) begin
            sealed_r <= 1'b0;
        end
    end

    // Sealed part has no backup, so time stops on supply loss
    assign tick_en = sec_tick && (!pf_s_r || !sealed_r);

    // Wrapping steps of the twelve-hour digits and of the month
    assign hr_step = bcd_inc({3'h0, hour_r[4:0]}, 8'h12, 8'h01);
    assign mo_step = bcd_inc({3'h0, mon_r[4:0]}, 8'h12, 8'h01);

    // Calendar carry chain for one second step
    always_comb begin
        sec_nxt = sec_r;
        min_nxt = min_r;
        hour_nxt = hour_r;
        day_nxt = day_r;
        date_nxt = date_r;
        mon_nxt = mon_r;
        year_nxt = year_r;
        midnight = 1'b0;
        if (tick_en) begin
            sec_nxt = bcd_inc(sec_r, 8'h59, 8'h00);
            if (sec_r == 8'h59) begin
                min_nxt = bcd_inc(min_r, 8'h59, 8'h00);
                if (min_r == 8'h59) begin
                    if (hour_r[`HOUR_12_BIT]) begin
                        // Twelve-hour form, no hour zero
                        if (hour_r[4:0] == 5'h11) begin
                            hour_nxt = {2'b01, ~hour_r[`HOUR_PM_BIT], 5'h12};
                            midnight = hour_r[`HOUR_PM_BIT];
                        end else if (hour_r[4:0] == 5'h12) begin
                            hour_nxt = {hour_r[7:5], 5'h01};
                        end else begin
                            hour_nxt = {1'b0, hour_r[6:5], hr_step[4:0]};
                        end
                    end else begin
                        // Twenty-four hour form, bit 5 is tens of twenty
                        midnight = (hour_r[5:0] == 6'h23);
                        hour_nxt = midnight ? 8'h00 : bcd_inc(hour_r, 8'h23, 8'h00);
                    end
                    if (midnight) begin
                        day_nxt = bcd_inc(day_r, 8'h07, 8'h01);
                        if (date_r == last_date(mon_r[4:0], year_r)) begin
                            date_nxt = 8'h01;
                            if (mon_r[4:0] == 5'h12) begin
                                mon_nxt = {~mon_r[`CENTURY_BIT] ^ (year_r != 8'h99),
                                           7'h01};
                                year_nxt = bcd_inc(year_r, 8'h99, 8'h00);
                            end else begin
                                mon_nxt = {mon_r[7], 2'b00, mo_step[4:0]};
                            end
                        end else begin
                            date_nxt = bcd_inc(date_r, 8'h31, 8'h01);
                        end
                    end
                end
            end
        end
    end

    // Host write to a time register, refused during power fail
    assign clk_wr = byte_evt && (state_r == ST_WRITE) && (ptr_r <= `A_YEAR) && !pf_s_r;
    assign ram_we = byte_evt && (state_r == ST_WRITE) && (ptr_r >= `RAM_BASE);

    // Main counters; host write of a register overrides its step
    always_ff @(posedge mclk) begin
        if (srst) begin
            sec_r <= `R_SEC;
            min_r <= `R_MIN;
            hour_r <= `R_HOUR;
            day_r <= `R_DAY;
            date_r <= `R_DATE;
            mon_r <= `R_MON;
            year_r <= `R_YEAR;
        end else begin
            sec_r <= (clk_wr && ptr_r == `A_SEC) ? rx_byte & `M_SEC : sec_nxt;
            min_r <= (clk_wr && ptr_r == `A_MIN) ? rx_byte & `M_MIN : min_nxt;
            hour_r <= (clk_wr && ptr_r == `A_HOUR) ? rx_byte & `M_HOUR : hour_nxt;
            day_r <= (clk_wr && ptr_r == `A_DAY) ? rx_byte & `M_DAY : day_nxt;
            date_r <= (clk_wr && ptr_r == `A_DATE) ? rx_byte & `M_DATE : date_nxt;
            mon_r <= (clk_wr && ptr_r == `A_MON) ? rx_byte & `M_MON : mon_nxt;
            year_r <= (clk_wr && ptr_r == `A_YEAR) ? rx_byte & `M_YEAR : year_nxt;
        end
    end

    // Pointer step with wrap inside its own space
    always_comb begin
        ptr_wrap = 1'b0;
        if (ptr_r == `CLK_TOP) begin
            ptr_nxt = `CLK_BASE;
            ptr_wrap = 1'b1;
        end else if (ptr_r == `RAM_TOP) begin
            ptr_nxt = `RAM_BASE;
        end else begin
            ptr_nxt = ptr_r + 7'h01;
        end
    end

    // Frame phase and pointer; first byte after CE rise is the address
    always_ff @(posedge mclk) begin
        if (srst) begin
            state_r <= ST_ADDR;
            ptr_r <= 7'h00;
        end else if (ce_rise) begin
            state_r <= ST_ADDR;
        end else if (byte_evt) begin
            if (state_r == ST_ADDR) begin
                ptr_r <= rx_byte[6:0];
                state_r <= rx_byte[`WR_FLAG_BIT] ? ST_WRITE : ST_READ;
            end else begin
                ptr_r <= ptr_nxt;
            end
        end
    end

    // Freeze time on select or on clock pointer wrap
    assign copy_en = ce_rise || (byte_evt && state_r != ST_ADDR && ptr_wrap);

    // Frozen copy read by the host while counters run on
    always_ff @(posedge mclk) begin
        if (srst) begin
            {sh_sec_r, sh_min_r, sh_hour_r, sh_day_r} <= {`R_SEC, `R_MIN, `R_HOUR, `R_DAY};
            {sh_date_r, sh_mon_r, sh_year_r} <= {`R_DATE, `R_MON, `R_YEAR};
        end else if (copy_en) begin
            {sh_sec_r, sh_min_r, sh_hour_r, sh_day_r} <= {sec_r, min_r, hour_r, day_r};
            {sh_date_r, sh_mon_r, sh_year_r} <= {date_r, mon_r, year_r};
        end
    end

    // Read data for the pointer; unused clock space reads zero
    always_comb begin
        tx_nxt = 8'h00;
        if (ptr_r >= `RAM_BASE) begin
            tx_nxt = ram_rdata;
        end else if (pf_s_r) begin
            tx_nxt = 8'h00;
        end else if (ptr_r == `A_SEC) begin
            tx_nxt = sh_sec_r;
        end else if (ptr_r == `A_MIN) begin
            tx_nxt = sh_min_r;
        end else if (ptr_r == `A_HOUR) begin
            tx_nxt = sh_hour_r;
        end else if (ptr_r == `A_DAY) begin
            tx_nxt = sh_day_r;
        end else if (ptr_r == `A_DATE) begin
            tx_nxt = sh_date_r;
        end else if (ptr_r == `A_MON) begin
            tx_nxt = sh_mon_r;
        end else if (ptr_r == `A_YEAR) begin
            tx_nxt = sh_year_r;
        end
    end

    // Offered byte; settles within a few cycles, host leaves a gap
    always_ff @(posedge mclk) begin
        if (srst) begin
            tx_data_r <= 8'h00;
        end else begin
            tx_data_r <= tx_nxt;
        end
    end

    // Checks and covers
    default clocking cb @(posedge mclk); endclocking
    default disable iff (srst);

    clk_ptr_wrap_a: assert property (byte_evt && state_r != ST_ADDR && !ce_rise &&
        ptr_r == `CLK_TOP |=> ptr_r == `CLK_BASE) else $error("clock pointer wrap");
    ram_ptr_wrap_a: assert property (byte_evt && state_r != ST_ADDR && !ce_rise &&
        ptr_r == `RAM_TOP |=> ptr_r == `RAM_BASE) else $error("RAM pointer wrap");
    shadow_copy_a: assert property (ce_rise |=> sh_sec_r == $past(sec_r) &&
        sh_year_r == $past(year_r)) else $error("shadow not loaded");
    shadow_hold_a: assert property (!copy_en |=> $stable(sh_sec_r) && $stable(sh_hour_r))
        else $error("shadow moved");
    day_wrap_a: assert property (midnight && day_r == 8'h07 && !clk_wr |=> day_r == 8'h01)
        else $error("weekday wrap");
    month_end_a: assert property (midnight && !clk_wr &&
        date_r == last_date(mon_r[4:0], year_r) |=> date_r == 8'h01)
        else $error("month end");
    century_flip_a: assert property (midnight && !clk_wr && year_r == 8'h99 &&
        date_r == 8'h31 && mon_r[4:0] == 5'h12 |=> mon_r[7] != $past(mon_r[7]) &&
        year_r == 8'h00) else $error("century bit");
    pm_toggle_a: assert property (tick_en && !clk_wr && hour_r[6] && hour_r[4:0] == 5'h11 &&
        min_r == 8'h59 && sec_r == 8'h59 |=> hour_r[4:0] == 5'h12 &&
        hour_r[5] != $past(hour_r[5])) else $error("PM toggle");
    no_hour_zero_a: assert property (hour_r[6] |-> hour_r[4:0] != 5'h00)
        else $error("12-hour zero");
    pf_read_a: assert property (pf_s_r && ptr_r < `RAM_BASE ##1 $stable(ptr_r) |->
        tx_data_r == 8'h00) else $error("read during power fail");
    stop_osc_a: assert property (!run_s_r && !clk_wr |=> $stable(sec_r) && $stable(div_r))
        else $error("time ran without oscillator");
    zero_bits_a: assert property (day_r[7:3] == 5'h00 && date_r[7:6] == 2'h0 &&
        mon_r[6:5] == 2'h0 && sec_r[7] == 1'b0) else $error("constant zero bit set");
    reset_time_a: assert property (disable iff (1'b0) srst |=> sec_r == `R_SEC &&
        hour_r == `R_HOUR && date_r == `R_DATE && day_r == `R_DAY)
        else $error("reset time");

    read_wrap_c: cover property (state_r == ST_READ && byte_evt && ptr_wrap);
    year_roll_c: cover property (mon_r[7] != $past(mon_r[7]) && !$past(clk_wr));
    ram_write_c: cover property (ram_we);
    clock_write_c: cover property (clk_wr && ptr_r == `A_HOUR);
endmodule

// file: verification/host_master.sv
// Host serial master model: chip enable, link clock and data toward the core
module host_master (
    input wire logic mclk,
    input wire logic sdo,
    output logic ce,
    output logic sclk,
    output logic sdi
);
    timeunit 1ns;
    timeprecision 100ps;
    // Idle: deselected, link clock parked high between frames
    initial begin
        ce = 1'b0;
        sclk = 1'b1;
        sdi = 1'b0;
    end
    // Select, then give the core time to see the rising enable
    task automatic open_frame();
        @(posedge mclk);
        ce <= 1'b1;
        repeat (6) @(posedge mclk);
    endtask
    // Deselect; the released data line flips so a stale level never looks valid
    task automatic close_frame();
        @(posedge mclk);
        ce <= 1'b0;
        sdi <= ~sdi;
        repeat (6) @(posedge mclk);
    endtask
    // One byte MSB first: drive on the falling link edge, sample on the rising one
    task automatic xbyte(input logic [7:0] tx, output logic [7:0] rx);
        for (int i = 7; i >= 0; i--) begin
            sclk = 1'b0;
            sdi = tx[i];
            #3;
            sclk = 1'b1;
            rx[i] = sdo;
            #3;
        end
        // Park high so the core can take the byte before the next one
        repeat (14) @(posedge mclk);
    endtask
endmodule

// file: verification/testbench.sv
// Self-checking bench for the clock core driven through the host model
module testbench;
    timeunit 1ns;
    timeprecision 100ps;
    logic mclk, srst, osc_32k, osc_run, vcc_below_threshold;
    logic ce, sclk, sdi, sdo, sdo_oe_n;
    logic sel; // Interface strap: 1 SPI, 0 three-wire
    int bad_count = 0;
    int compares = 0;
    logic [7:0] rx;
    logic [7:0] got [7];
    // Short second keeps the run brief
    localparam int DIV = 4;
    // Power-on time and date
    logic [7:0] pwr [7] = '{8'h00, 8'h00, 8'h00, 8'h01, 8'h01, 8'h01, 8'h00};
    // Year end, leap February, 12-hour noon, 24-hour twenties; valid, weekdays in range
    logic [7:0] setv [4][7] = '{'{8'h59, 8'h59, 8'h23, 8'h07, 8'h31, 8'h12, 8'h99},
        '{8'h59, 8'h59, 8'h23, 8'h03, 8'h28, 8'h02, 8'h24},
        '{8'h59, 8'h59, 8'h51, 8'h02, 8'h10, 8'h05, 8'h10},
        '{8'h59, 8'h59, 8'h19, 8'h02, 8'h30, 8'h04, 8'h10}};
    // Same values one second later
    logic [7:0] expv [4][7] = '{'{8'h00, 8'h00, 8'h00, 8'h01, 8'h01, 8'h81, 8'h00},
        '{8'h00, 8'h00, 8'h00, 8'h04, 8'h29, 8'h02, 8'h24},
        '{8'h00, 8'h00, 8'h72, 8'h02, 8'h10, 8'h05, 8'h10},
        '{8'h00, 8'h00, 8'h20, 8'h02, 8'h30, 8'h04, 8'h10}};

    bcd_clock_calendar_core #(.OSC_DIV(DIV)) bcd_clock_calendar_core_i (.mclk(mclk),
        .srst(srst), .sclk(sclk), .ce(ce), .sdi(sdi), .interface_select(sel),
        .osc_32k(osc_32k), .osc_run(osc_run),
        .vcc_below_threshold(vcc_below_threshold), .sdo(sdo), .sdo_oe_n(sdo_oe_n));
    host_master host_master_i (.mclk(mclk), .sdo(sdo), .ce(ce), .sclk(sclk), .sdi(sdi));

    // Core clock, 40 ns
    initial begin
        mclk = 1'b0;
        forever #20 mclk = ~mclk;
    end
    // Compare and count
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        compares++;
        if (seen !== exp) begin
            bad_count++;
            $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    // Single byte write frame
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        host_master_i.open_frame();
        host_master_i.xbyte(8'h80 | a, rx);
        host_master_i.xbyte(d, rx);
        host_master_i.close_frame();
    endtask
    // Single byte read frame; data pin enable checked around the byte
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        host_master_i.open_frame();
        host_master_i.xbyte(a, rx);
        check({7'h00, sdo_oe_n}, {7'h00, ~sel});
        host_master_i.xbyte(8'h00, d);
        check({7'h00, sdo_oe_n}, 8'h00);
        host_master_i.close_frame();
        check({7'h00, sdo_oe_n}, 8'h01);
    endtask
    // Seven byte read burst
    task automatic rd7(input logic [7:0] a);
        host_master_i.open_frame();
        host_master_i.xbyte(a, rx);
        for (int i = 0; i < 7; i++) begin
            host_master_i.xbyte(8'h00, got[i]);
        end
        host_master_i.close_frame();
    endtask
    // One second of crystal edges
    task automatic tick();
        repeat (DIV) begin
            @(posedge mclk) osc_32k <= 1'b1;
            repeat (4) @(posedge mclk);
            osc_32k <= 1'b0;
            repeat (4) @(posedge mclk);
        end
        repeat (8) @(posedge mclk);
    endtask
    // Counts, verdict and stop
    task automatic end_of_test();
        $display("Compares %0d, mismatches %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    // Hang guard
    initial begin
        #1ms;
        bad_count++;
        end_of_test();
    end
    // Main sequence
    initial begin
        srst = 1'b1;
        sel = 1'b1;
        osc_32k = 1'b0;
        osc_run = 1'b1;
        vcc_below_threshold = 1'b0;
        repeat (6) @(posedge mclk);
        srst <= 1'b0;
        repeat (6) @(posedge mclk);
        rd7(8'h00);
        for (int i = 0; i < 7; i++) check(got[i], pwr[i]);
        // Write a burst, let one second pass, read it back
        for (int c = 0; c < 4; c++) begin
            host_master_i.open_frame();
            host_master_i.xbyte(8'h80, rx);
            for (int i = 0; i < 7; i++) host_master_i.xbyte(setv[c][i], rx);
            host_master_i.close_frame();
            tick();
            rd7(8'h00);
            for (int i = 0; i < 2; i++) check(got[i], expv[c][i]);
            check(got[2], expv[c][2]);
            check(got[3], expv[c][3]);
            check(got[4], expv[c][4]);
            for (int i = 5; i < 7; i++) check(got[i], expv[c][i]);
        end
        wr(8'h03, 8'hFF);
        rd(8'h03, rx);
        check(rx, 8'h07);
        wr(8'h00, 8'hD9);
        rd(8'h00, rx);
        check(rx, 8'h59);
        // Supply failing: clock registers closed
        vcc_below_threshold <= 1'b1;
        repeat (8) @(posedge mclk);
        wr(8'h00, 8'h30);
        rd(8'h00, rx);
        check(rx, 8'h00);
        vcc_below_threshold <= 1'b0;
        repeat (8) @(posedge mclk);
        rd(8'h00, rx);
        check(rx, 8'h59);
        // Pointer wrap from the top clock address
        rd7(8'h1F);
        check(got[0], 8'h00);
        check(got[1], 8'h59);
        // Time frozen inside a frame while the counters move on
        host_master_i.open_frame();
        host_master_i.xbyte(8'h00, rx);
        tick();
        host_master_i.xbyte(8'h00, rx);
        host_master_i.close_frame();
        check(rx, 8'h59);
        rd(8'h00, rx);
        check(rx, 8'h00);
        // Oscillator stopped: crystal edges must not move the time
        osc_run <= 1'b0;
        repeat (8) @(posedge mclk);
        tick();
        osc_run <= 1'b1;
        repeat (8) @(posedge mclk);
        rd(8'h00, rx);
        check(rx, 8'h00);
        // RAM burst wraps to its own base
        host_master_i.open_frame();
        host_master_i.xbyte(8'hFF, rx);
        host_master_i.xbyte(8'hA5, rx);
        host_master_i.xbyte(8'h5A, rx);
        host_master_i.close_frame();
        rd(8'h20, rx);
        check(rx, 8'h5A);
        rd(8'h7F, rx);
        check(rx, 8'hA5);
        // Reset with supply failing: sealed, so a second passes without backup
        vcc_below_threshold <= 1'b1;
        srst <= 1'b1;
        repeat (6) @(posedge mclk);
        srst <= 1'b0;
        repeat (6) @(posedge mclk);
        tick();
        vcc_below_threshold <= 1'b0;
        repeat (8) @(posedge mclk);
        rd(8'h00, rx);
        check(rx, 8'h00);
        // Three-wire strap: shared pin released outside read data
        sel <= 1'b0;
        rd(8'h20, rx);
        check(rx, 8'h5A);
        end_of_test();
    end
endmodule
